/* tb/pesd_decoder_asserts.sv */
/*
  Port-level assertions for the event decoder, bound into pesd_decoder.
  Assumes a zero-wait APB slave; the select register is shadowed off the bus.
*/
`timescale 1ns/1ps
`default_nettype none
module pesd_decoder_asserts #(
  parameter int CNT_W = 32
) (
  input wire logic             pclk,
  input wire logic             presetn,
  input wire logic             psel,
  input wire logic             penable,
  input wire logic             pwrite,
  input wire logic [7:0]       paddr,
  input wire logic [31:0]      pwdata,
  input wire logic             page_walker_busy,
  input wire logic             decode_queue_full_stall_event,
  input wire logic             br_exec_valid,
  input wire logic             br_exec_mispred,
  input wire logic [2:0]       loop_stream_detector_uops,
  input wire logic [CNT_W-1:0] count_value,
  input wire logic             count_tick
);
  // ==========================================================================
  // shadow select
  logic [31:0] sel_ff;
  logic        cnt_wr;
  logic        plain;
  logic [15:0] code;
  // a count write wins over an increment, so those edges are left out
  assign cnt_wr = psel && penable && pwrite && paddr == pesd_pkg::PESD_OFS_COUNT;
  assign plain  = sel_ff[22] && sel_ff[31:24] == 8'h00 && !cnt_wr;
  assign code   = {sel_ff[7:0], sel_ff[15:8]};
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sel_ff <= '0;
    end else if (psel && penable && pwrite && paddr == pesd_pkg::PESD_OFS_EVTSEL) begin
      sel_ff <= pwdata;
    end
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ==========================================================================
  // properties
  property p_walk;
    plain && code == 16'h8510 && page_walker_busy |=> count_value == $past(count_value) + 1;
  endproperty
  a_walk: assert property (p_walk) else $error("walk cycle missed");
  property p_iq;
    plain && code == 16'h8704 && decode_queue_full_stall_event |=> count_value == $past(count_value) + 1;
  endproperty
  a_iq: assert property (p_iq) else $error("queue full stall missed");
  property p_brall;
    plain && code == 16'h88FF && br_exec_valid |=> count_value == $past(count_value) + 1;
  endproperty
  a_brall: assert property (p_brall) else $error("branch missed");
  property p_misp;
    plain && code == 16'h89FF && br_exec_valid |=> count_value == $past(count_value) + $past(br_exec_mispred);
  endproperty
  a_misp: assert property (p_misp) else $error("mispredict count wrong");
  property p_loop;
    plain && code == 16'hA801 |=> count_value == $past(count_value) + $past(loop_stream_detector_uops);
  endproperty
  a_loop: assert property (p_loop) else $error("loop uops wrong");
  property p_thr;
    sel_ff[22] && sel_ff[31:24] != 8'h00 && !cnt_wr |=> count_value - $past(count_value) <= 1;
  endproperty
  a_thr: assert property (p_thr) else $error("threshold step above one");
  property p_dis;
    !sel_ff[22] && !cnt_wr |=> $stable(count_value);
  endproperty
  a_dis: assert property (p_dis) else $error("disabled counter moved");
  property p_tick;
    !cnt_wr |=> count_tick == (count_value != $past(count_value));
  endproperty
  a_tick: assert property (p_tick) else $error("tick disagrees with count");
  c_walk: cover property (plain && code == 16'h8510 && page_walker_busy);
  c_thr: cover property (sel_ff[22] && sel_ff[31:24] != 8'h00 && count_tick);
  c_misp: cover property (plain && code == 16'h89FF && br_exec_mispred);
endmodule
bind pesd_decoder pesd_decoder_asserts #(.CNT_W(CNT_W)) u_chk (.*);
`default_nettype wire

/* tb/pesd_pipe_model.sv */
/*
  Pipeline model: random event strobes for the decoder while run is high.
  Assumes run changes just after pclk rises; strobes idle low otherwise, br_exec_type idles at 01H.
*/
`timescale 1ns/1ps
`default_nettype none
module pesd_pipe_model (
  input  wire logic  pclk,
  input  wire logic  run,
  output logic       page_walker_busy,
  output logic       second_level_translation_buffer_hit_4k,
  output logic       second_level_translation_buffer_hit_2m,
  output logic       length_changing_prefix_stall,
  output logic       decode_queue_full_stall_event,
  output logic       br_exec_valid,
  output logic       br_exec_taken,
  output logic       br_exec_mispred,
  output logic [5:0] br_exec_type,
  output logic [2:0] fe_undelivered_slots,
  output logic [2:0] loop_stream_detector_uops,
  output logic       backend_stall,
  output logic       exec_stall,
  output logic       l2_miss_load,
  output logic       instruction_translation_buffer_flush,
  output logic [7:0] dispatch_port_thread,
  output logic [7:0] dispatch_port_core,
  output logic       alloc_stall_any,
  output logic       alloc_stall_reservation_station,
  output logic       alloc_stall_store_buffer,
  output logic       alloc_stall_reorder_buffer,
  output logic       offcore_demand_data_rd,
  output logic       offcore_demand_code_rd,
  output logic       offcore_read_for_ownership,
  output logic       offcore_prefetch_data_rd,
  output logic [3:0] l2_miss_loads_pending,
  output logic [3:0] mem_loads_pending,
  output logic [3:0] l1d_miss_loads_pending,
  output logic [3:0] core_uops_executed
);
  logic [63:0] rnd_ff;
  // quiet between runs so select changes never meet live events
  always_ff @(posedge pclk) begin
    rnd_ff <= run ? {$urandom, $urandom} : 64'h0000_0000_0000_0000;
  end
  assign br_exec_type         = 6'h01 << (rnd_ff[2:0] % 3'd6);
  assign fe_undelivered_slots = (rnd_ff[5:3] > 3'd4) ? 3'd4 : rnd_ff[5:3];
  // one translation miss per cycle
  assign second_level_translation_buffer_hit_2m = rnd_ff[60] && !second_level_translation_buffer_hit_4k;
  assign {page_walker_busy, second_level_translation_buffer_hit_4k, length_changing_prefix_stall, decode_queue_full_stall_event,
          br_exec_valid, br_exec_taken, br_exec_mispred, backend_stall, exec_stall, l2_miss_load, instruction_translation_buffer_flush,
          alloc_stall_any, alloc_stall_reservation_station, alloc_stall_store_buffer, alloc_stall_reorder_buffer,
          offcore_demand_data_rd, offcore_demand_code_rd, offcore_read_for_ownership, offcore_prefetch_data_rd,
          loop_stream_detector_uops, dispatch_port_thread, dispatch_port_core, l2_miss_loads_pending,
          mem_loads_pending, l1d_miss_loads_pending, core_uops_executed} = rnd_ff[59:6];
endmodule
`default_nettype wire

/* tb/test_pesd_decoder.sv */
/*
  Self-checking bench: APB master, random pipeline strobes, reference tally.
  Assumes the zero-wait slave and registered counter of the hand-over.
*/
`timescale 1ns/1ps
`default_nettype none
module test_pesd_decoder;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, run, err, count_tick;
  logic [7:0]  paddr, dispatch_port_thread, dispatch_port_core;
  logic [31:0] pwdata, prdata, rd, exp_cnt, count_value;
  logic [5:0]  br_exec_type;
  logic [3:0]  l2_miss_loads_pending, mem_loads_pending, l1d_miss_loads_pending, core_uops_executed;
  logic [2:0]  fe_undelivered_slots, loop_stream_detector_uops;
  logic        page_walker_busy, second_level_translation_buffer_hit_4k, second_level_translation_buffer_hit_2m, length_changing_prefix_stall, decode_queue_full_stall_event;
  logic        br_exec_valid, br_exec_taken, br_exec_mispred, backend_stall, exec_stall, l2_miss_load, instruction_translation_buffer_flush;
  logic        alloc_stall_any, alloc_stall_reservation_station, alloc_stall_store_buffer, alloc_stall_reorder_buffer;
  logic        offcore_demand_data_rd, offcore_demand_code_rd, offcore_read_for_ownership, offcore_prefetch_data_rd;
  int          n_errors, comparisons, cyc;
  logic [15:0] codes [$] = '{16'h8510, 16'h8520, 16'h8540, 16'h8560, 16'h8701, 16'h8704, 16'h8881, 16'h8841,
    16'h88C1, 16'h8882, 16'h8884, 16'h8888, 16'h8890, 16'h88A0, 16'h8842, 16'h88FF, 16'h8981, 16'h8941, 16'h8988,
    16'h89FF, 16'h9C01, 16'hA101, 16'hA180, 16'hA2FF, 16'hA201, 16'hA204, 16'hA208, 16'hA210, 16'hA305, 16'hA30C,
    16'hA801, 16'hAE01, 16'hB001, 16'hB002, 16'hB004, 16'hB008, 16'hB102, 16'h0000};
  pesd_decoder u_dut (.*);
  pesd_pipe_model u_pipe (.*);
  initial begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end
  // ==========================================================================
  // reference
  function automatic logic [7:0] raw(logic [7:0] ev, logic [7:0] um, logic all);
    logic hit;
    hit = br_exec_valid && (um == 8'hFF || (|(um[5:0] & br_exec_type)
          && (br_exec_taken ? um[7] : um[6] && br_exec_type[0])));
    if (ev == 8'h88) return 8'(hit);
    if (ev == 8'h89) return 8'(hit && br_exec_mispred);
    if (ev == 8'hA1) return 8'($countones(um & (all ? dispatch_port_core : dispatch_port_thread)));
    case ({ev, um})
      16'h8510: return 8'(page_walker_busy);
      16'h8520: return 8'(second_level_translation_buffer_hit_4k);
      16'h8540: return 8'(second_level_translation_buffer_hit_2m);
      16'h8560: return 8'(second_level_translation_buffer_hit_4k | second_level_translation_buffer_hit_2m);
      16'h8701: return 8'(length_changing_prefix_stall);
      16'h8704: return 8'(decode_queue_full_stall_event);
      16'h9C01: return backend_stall ? 8'h00 : 8'(fe_undelivered_slots);
      16'hA201: return 8'(alloc_stall_any);
      16'hA204: return 8'(alloc_stall_reservation_station);
      16'hA208: return 8'(alloc_stall_store_buffer);
      16'hA210: return 8'(alloc_stall_reorder_buffer);
      16'hA301: return 8'(l2_miss_loads_pending);
      16'hA302: return 8'(mem_loads_pending);
      16'hA305: return 8'(l2_miss_load);
      16'hA308: return 8'(l1d_miss_loads_pending);
      16'hA30C: return exec_stall ? 8'(l1d_miss_loads_pending) : 8'h00;
      16'hA801: return 8'(loop_stream_detector_uops);
      16'hAE01: return 8'(instruction_translation_buffer_flush);
      16'hB001: return 8'(offcore_demand_data_rd);
      16'hB002: return 8'(offcore_demand_code_rd);
      16'hB004: return 8'(offcore_read_for_ownership);
      16'hB008: return 8'(offcore_demand_data_rd | offcore_prefetch_data_rd);
      16'hB102: return 8'(core_uops_executed);
      default: return 8'h00;
    endcase
  endfunction
  function automatic logic [7:0] inc(logic [31:0] sel);
    logic [7:0] r;
    r = raw(sel[7:0], sel[15:8], sel[21]);
    return (sel[31:24] != 8'h00) ? 8'(r >= sel[31:24]) : r;
  endfunction
  function automatic logic [31:0] mk(logic [15:0] c, logic [7:0] thr, logic all);
    return {thr, 2'b01, all, 5'h00, c[7:0], c[15:8]};
  endfunction
  // ==========================================================================
  // bus and checks
  task automatic chk(string what, logic [31:0] e, logic [31:0] s);
    comparisons++;
    if (s !== e) begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, e, s);
    end
  endtask
  task automatic apb(logic w, logic [7:0] a, logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // pready high ends this wait; only the bench timeout ends a hang
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic run_sel(logic [31:0] sel, int n);
    apb(1'b1, pesd_pkg::PESD_OFS_EVTSEL, 32'h0000_0000);
    apb(1'b1, pesd_pkg::PESD_OFS_COUNT, 32'h0000_0000);
    apb(1'b1, pesd_pkg::PESD_OFS_EVTSEL, sel);
    exp_cnt = 32'h0000_0000;
    run <= 1'b1;
    for (int i = 0; i < n + 3; i++) begin
      @(posedge pclk);
      exp_cnt += 32'(inc(sel));
      if (i == n) run <= 1'b0;
    end
    apb(1'b0, pesd_pkg::PESD_OFS_COUNT, 32'h0000_0000);
    chk("count", exp_cnt, rd);
  endtask
  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  // a hang counts as a mismatch and still reports
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 30000) begin
      n_errors++;
      give_verdict();
    end
  end
  // ==========================================================================
  // sequence
  initial begin
    void'($urandom(32'h0000_84a0));
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    run = 1'b0;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, pesd_pkg::PESD_OFS_EVTSEL, 32'h0000_0000);
    chk("select reset", pesd_pkg::PESD_EVTSEL_RST, rd);
    apb(1'b0, pesd_pkg::PESD_OFS_COUNT, 32'h0000_0000);
    chk("count reset", pesd_pkg::PESD_COUNT_RST, rd);
    exp_cnt = $urandom;
    apb(1'b1, pesd_pkg::PESD_OFS_EVTSEL, exp_cnt);
    exp_cnt &= pesd_pkg::PESD_EVTSEL_RMASK;
    apb(1'b0, pesd_pkg::PESD_OFS_EVTSEL, 32'h0000_0000);
    chk("select readback", exp_cnt, rd);
    apb(1'b0, 8'h0C, 32'h0000_0000);
    chk("unmapped error", 32'h0000_0001, {31'h0, err});
    chk("unmapped data", 32'h0000_0000, rd);
    // strobes idle here, so any select adds nothing
    exp_cnt = $urandom;
    apb(1'b1, pesd_pkg::PESD_OFS_COUNT, exp_cnt);
    apb(1'b0, pesd_pkg::PESD_OFS_COUNT, 32'h0000_0000);
    chk("count write", exp_cnt, rd);
    chk("count error", 32'h0000_0000, {31'h0, err});
    apb(1'b0, pesd_pkg::PESD_OFS_STATUS, 32'h0000_0000);
    chk("status idle", 32'h0000_0000, rd);
    for (int p = 0; p < 3; p++) begin
      foreach (codes[i]) begin
        run_sel(mk(codes[i], (p == 2) ? 8'($urandom_range(3, 1)) : 8'h00, p[0] | (p[1] & 1'($urandom))), 40);
      end
    end
    run_sel(mk(16'hA301, 8'h02, 1'b0), 60);
    run_sel(mk(16'hA302, 8'h02, 1'b0), 60);
    run_sel(mk(16'hA308, 8'h08, 1'b0), 60);
    give_verdict();
  end
endmodule
`default_nettype wire

/* verilog/pesd_decoder.sv */
/*
  Event select decoder with one counter behind an APB slave.
  Assumes pipeline strobes are synchronous to pclk and valid every cycle;
  an APB master driving psel/penable per the protocol.
*/
// Added by the designer: the APB register port and the address map.
`timescale 1ns/1ps
`default_nettype none

// How it works
// - event 85H mask 10H counts each cycle the page walker is walking.
// - 85H masks 20H/40H/60H count translation misses hitting second level, 4K/2M/either.
// - 87H mask 01H counts prefix stalls, mask 04H counts queue-full stall cycles.
// - 88H bit 80H qualifies taken branches, combined with type bits 01H..20H.
// - type bit 01H picks conditional branches, combined with taken and/or not-taken.
// - bit 40H picks not-taken branches, meaningful with conditional bit only.
// - bits 02H..20H pick jump, indirect jump, return, direct and indirect call, taken only.
// - branch mask FFH counts every executed near branch.
// - 89H uses the same decode but counts only mispredicted branches.
// - 9CH mask 01H adds undelivered front-end slots while back end not stalled.
// - A1H one-hot mask picks port 0..7 dispatch; all-thread bit counts per core.
// - A2H counts allocation stalls: any, reservation station, store buffer, reorder buffer.
// - A3H mask 01H counts pending second-level miss loads, threshold 2 gives cycles.
// - A3H masks 08H and 0CH count first-level miss activity, third counter only.
// - A3H mask 02H counts pending memory loads, threshold 2 gives cycles.
// - A8H mask 01H adds loop stream detector micro-ops each cycle.
// - AEH mask 01H counts instruction translation buffer flushes.
// - B0H masks 01H/02H/04H/08H count off-core data, code, ownership, all-data reads.
// - B1H mask 02H adds core-wide executed micro-ops each cycle.
// - A3H mask 05H counts loads that missed the second-level cache.
module pesd_decoder #(
  parameter int CNT_W       = 32,
  parameter int COUNTER_IDX = 2
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic             pslverr,
  output logic      [31:0] prdata,
  input  wire logic        page_walker_busy,
  input  wire logic        second_level_translation_buffer_hit_4k,
  input  wire logic        second_level_translation_buffer_hit_2m,
  input  wire logic        length_changing_prefix_stall,
  input  wire logic        decode_queue_full_stall_event,
  input  wire logic        br_exec_valid,
  input  wire logic [5:0]  br_exec_type,
  input  wire logic        br_exec_taken,
  input  wire logic        br_exec_mispred,
  input  wire logic [2:0]  fe_undelivered_slots,
  input  wire logic        backend_stall,
  input  wire logic [7:0]  dispatch_port_thread,
  input  wire logic [7:0]  dispatch_port_core,
  input  wire logic        alloc_stall_any,
  input  wire logic        alloc_stall_reservation_station,
  input  wire logic        alloc_stall_store_buffer,
  input  wire logic        alloc_stall_reorder_buffer,
  input  wire logic [3:0]  l2_miss_loads_pending,
  input  wire logic [3:0]  mem_loads_pending,
  input  wire logic [3:0]  l1d_miss_loads_pending,
  input  wire logic        exec_stall,
  input  wire logic        l2_miss_load,
  input  wire logic [2:0]  loop_stream_detector_uops,
  input  wire logic        instruction_translation_buffer_flush,
  input  wire logic        offcore_demand_data_rd,
  input  wire logic        offcore_demand_code_rd,
  input  wire logic        offcore_read_for_ownership,
  input  wire logic        offcore_prefetch_data_rd,
  input  wire logic [3:0]  core_uops_executed,
  output logic [CNT_W-1:0] count_value,
  output logic             count_tick
);

  // ==========================================================================
  // state
  typedef struct packed {
    logic [7:0]       evt;
    logic [7:0]       umask;
    logic             any_thread;
    logic             enable;
    logic [7:0]       thresh;
    logic [CNT_W-1:0] count;
    logic             tick;
    logic             slverr;
    logic [31:0]      rdata;
  } pesd_state_s;

  pesd_state_s st_ff;
  pesd_state_s nxt_st;

  // ==========================================================================
  // helpers
  function automatic logic [3:0] pesd_popcnt8(input logic [7:0] v);
    logic [3:0] n;
    n = 4'h0;
    for (int i = 0; i < 8; i++) begin
      n = n + {3'b000, v[i]};
    end
    return n;
  endfunction

  // taken/not-taken qualifiers against the one-hot branch type
  function automatic logic pesd_br_match(input logic [7:0] um,
                                         input logic [5:0] btype,
                                         input logic       taken);
    logic hit_type;
    logic cond_dir;
    hit_type = |(um[pesd_pkg::PESD_BR_TYPES-1:0] & btype);
    cond_dir = (taken & um[pesd_pkg::PESD_BR_TAKEN_BIT]) |
               (~taken & um[pesd_pkg::PESD_BR_NOTTAKEN_BIT]);
    if (um == pesd_pkg::PESD_UM_FF) begin
      return 1'b1;
    end
    if (btype[pesd_pkg::PESD_BR_COND_BIT]) begin
      return hit_type & cond_dir;
    end
    // non-conditional kinds qualify on taken only
    return hit_type & taken & um[pesd_pkg::PESD_BR_TAKEN_BIT];
  endfunction

  // ==========================================================================
  // raw per-cycle event count
  logic [3:0] raw_cnt;
  logic       br_hit;
  logic       l1d_ok;

  always_comb begin
    raw_cnt = 4'h0;
    br_hit  = br_exec_valid && pesd_br_match(st_ff.umask, br_exec_type, br_exec_taken);
    // the first-level miss activity exists only on one counter instance
    l1d_ok  = (COUNTER_IDX == pesd_pkg::PESD_L1D_COUNTER_IDX);
    unique case (st_ff.evt)
      pesd_pkg::PESD_EV_INSTRUCTION_TRANSLATION_BUFFER: begin
        unique case (st_ff.umask)
          pesd_pkg::PESD_UM_10: raw_cnt = {3'b000, page_walker_busy};
          pesd_pkg::PESD_UM_20: raw_cnt = {3'b000, second_level_translation_buffer_hit_4k};
          pesd_pkg::PESD_UM_40: raw_cnt = {3'b000, second_level_translation_buffer_hit_2m};
          pesd_pkg::PESD_UM_60: raw_cnt = {3'b000, second_level_translation_buffer_hit_4k | second_level_translation_buffer_hit_2m};
          default:              raw_cnt = 4'h0;
        endcase
      end
      pesd_pkg::PESD_EV_DECODE: begin
        unique case (st_ff.umask)
          pesd_pkg::PESD_UM_01: raw_cnt = {3'b000, length_changing_prefix_stall};
          pesd_pkg::PESD_UM_04: raw_cnt = {3'b000, decode_queue_full_stall_event};
          default:              raw_cnt = 4'h0;
        endcase
      end
      pesd_pkg::PESD_EV_BREXEC: raw_cnt = {3'b000, br_hit};
      pesd_pkg::PESD_EV_BRMISP: raw_cnt = {3'b000, br_hit & br_exec_mispred};
      pesd_pkg::PESD_EV_FEGAP: begin
        if (st_ff.umask == pesd_pkg::PESD_UM_01 && !backend_stall) begin
          raw_cnt = {1'b0, fe_undelivered_slots};
        end
      end
      pesd_pkg::PESD_EV_PORT: begin
        // mask is one-hot per port; several bits simply sum their ports
        raw_cnt = pesd_popcnt8(st_ff.umask &
                  (st_ff.any_thread ? dispatch_port_core : dispatch_port_thread));
      end
      pesd_pkg::PESD_EV_ALLOC: begin
        unique case (st_ff.umask)
          pesd_pkg::PESD_UM_01: raw_cnt = {3'b000, alloc_stall_any};
          pesd_pkg::PESD_UM_04: raw_cnt = {3'b000, alloc_stall_reservation_station};
          pesd_pkg::PESD_UM_08: raw_cnt = {3'b000, alloc_stall_store_buffer};
          pesd_pkg::PESD_UM_10: raw_cnt = {3'b000, alloc_stall_reorder_buffer};
          default:              raw_cnt = 4'h0;
        endcase
      end
      pesd_pkg::PESD_EV_CYCACT: begin
        unique case (st_ff.umask)
          pesd_pkg::PESD_UM_01: raw_cnt = l2_miss_loads_pending;
          pesd_pkg::PESD_UM_02: raw_cnt = mem_loads_pending;
          pesd_pkg::PESD_UM_05: raw_cnt = {3'b000, l2_miss_load};
          pesd_pkg::PESD_UM_08: raw_cnt = l1d_ok ? l1d_miss_loads_pending : 4'h0;
          pesd_pkg::PESD_UM_0C: raw_cnt = (l1d_ok && exec_stall) ?
                                          l1d_miss_loads_pending : 4'h0;
          default:              raw_cnt = 4'h0;
        endcase
      end
      pesd_pkg::PESD_EV_LOOP: begin
        if (st_ff.umask == pesd_pkg::PESD_UM_01) begin
          raw_cnt = {1'b0, loop_stream_detector_uops};
        end
      end
      pesd_pkg::PESD_EV_ITFL: begin
        if (st_ff.umask == pesd_pkg::PESD_UM_01) begin
          raw_cnt = {3'b000, instruction_translation_buffer_flush};
        end
      end
      pesd_pkg::PESD_EV_OFFC: begin
        unique case (st_ff.umask)
          pesd_pkg::PESD_UM_01: raw_cnt = {3'b000, offcore_demand_data_rd};
          pesd_pkg::PESD_UM_02: raw_cnt = {3'b000, offcore_demand_code_rd};
          pesd_pkg::PESD_UM_04: raw_cnt = {3'b000, offcore_read_for_ownership};
          pesd_pkg::PESD_UM_08: raw_cnt = {3'b000, offcore_demand_data_rd
                                                   | offcore_prefetch_data_rd};
          default:              raw_cnt = 4'h0;
        endcase
      end
      pesd_pkg::PESD_EV_UOPCR: begin
        // core-wide already, so the all-thread bit is not needed here
        if (st_ff.umask == pesd_pkg::PESD_UM_02) begin
          raw_cnt = core_uops_executed;
        end
      end
      default: raw_cnt = 4'h0;
    endcase
  end

  // ==========================================================================
  // threshold and increment
  logic [3:0] inc;

  always_comb begin
    if (st_ff.thresh != 8'h00) begin
      inc = ({4'h0, raw_cnt} >= st_ff.thresh) ? 4'h1 : 4'h0;
    end else begin
      inc = raw_cnt;
    end
  end

  // ==========================================================================
  // apb decode and next state
  logic setup;
  logic access;

  always_comb begin
    setup  = psel && !penable;
    access = psel && penable;
    nxt_st = st_ff;
    nxt_st.tick = 1'b0;
    if (st_ff.enable) begin
      nxt_st.count = st_ff.count + CNT_W'(inc);
      nxt_st.tick  = (inc != 4'h0);
    end
    // read data and error captured in setup so both come from flops
    if (setup) begin
      nxt_st.slverr = 1'b0;
      nxt_st.rdata  = 32'h0000_0000;
      unique case (paddr)
        pesd_pkg::PESD_OFS_EVTSEL: begin
          nxt_st.rdata[pesd_pkg::PESD_EVT_LSB  +: 8] = st_ff.evt;
          nxt_st.rdata[pesd_pkg::PESD_MASK_LSB +: 8] = st_ff.umask;
          nxt_st.rdata[pesd_pkg::PESD_ANY_BIT]       = st_ff.any_thread;
          nxt_st.rdata[pesd_pkg::PESD_EN_BIT]        = st_ff.enable;
          nxt_st.rdata[pesd_pkg::PESD_THR_LSB  +: 8] = st_ff.thresh;
        end
        pesd_pkg::PESD_OFS_COUNT:  nxt_st.rdata = 32'(st_ff.count);
        pesd_pkg::PESD_OFS_STATUS: nxt_st.rdata = {28'h000_0000, inc};
        default:                   nxt_st.slverr = 1'b1;
      endcase
    end
    // software write wins over the running increment
    if (access && pwrite) begin
      unique case (paddr)
        pesd_pkg::PESD_OFS_EVTSEL: begin
          nxt_st.evt        = pwdata[pesd_pkg::PESD_EVT_LSB  +: 8];
          nxt_st.umask      = pwdata[pesd_pkg::PESD_MASK_LSB +: 8];
          nxt_st.any_thread = pwdata[pesd_pkg::PESD_ANY_BIT];
          nxt_st.enable     = pwdata[pesd_pkg::PESD_EN_BIT];
          nxt_st.thresh     = pwdata[pesd_pkg::PESD_THR_LSB  +: 8];
        end
        pesd_pkg::PESD_OFS_COUNT: nxt_st.count = CNT_W'(pwdata);
        default: ;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // ==========================================================================
  // outputs
  assign pready      = 1'b1;
  assign pslverr     = access && st_ff.slverr;
  assign prdata      = st_ff.rdata;
  assign count_value = st_ff.count;
  assign count_tick  = st_ff.tick;

endmodule

`default_nettype wire

/* verilog/pesd_pkg.sv */
/*
  Constants for the performance event select decoder: register map, select
  field layout, event codes and unit masks.
  Assumes a 32-bit APB register bus and per-cycle strobes from the pipeline.
*/
`default_nettype none

package pesd_pkg;

  // ==========================================================================
  // register map (byte addresses)
  localparam logic [7:0] PESD_OFS_EVTSEL = 8'h00;
  localparam logic [7:0] PESD_OFS_COUNT  = 8'h04;
  localparam logic [7:0] PESD_OFS_STATUS = 8'h08;

  // ==========================================================================
  // select register fields
  localparam int PESD_EVT_LSB  = 0;
  localparam int PESD_MASK_LSB = 8;
  localparam int PESD_ANY_BIT  = 21;
  localparam int PESD_EN_BIT   = 22;
  localparam int PESD_THR_LSB  = 24;
  localparam logic [31:0] PESD_EVTSEL_RMASK = 32'hFF60_FFFF;
  localparam logic [31:0] PESD_EVTSEL_RST   = 32'h0000_0000;
  localparam logic [31:0] PESD_COUNT_RST    = 32'h0000_0000;

  // ==========================================================================
  // event codes
  localparam logic [7:0] PESD_EV_INSTRUCTION_TRANSLATION_BUFFER   = 8'h85;
  localparam logic [7:0] PESD_EV_DECODE = 8'h87;
  localparam logic [7:0] PESD_EV_BREXEC = 8'h88;
  localparam logic [7:0] PESD_EV_BRMISP = 8'h89;
  localparam logic [7:0] PESD_EV_FEGAP  = 8'h9C;
  localparam logic [7:0] PESD_EV_PORT   = 8'hA1;
  localparam logic [7:0] PESD_EV_ALLOC  = 8'hA2;
  localparam logic [7:0] PESD_EV_CYCACT = 8'hA3;
  localparam logic [7:0] PESD_EV_LOOP   = 8'hA8;
  localparam logic [7:0] PESD_EV_ITFL   = 8'hAE;
  localparam logic [7:0] PESD_EV_OFFC   = 8'hB0;
  localparam logic [7:0] PESD_EV_UOPCR  = 8'hB1;

  // ==========================================================================
  // unit masks
  localparam logic [7:0] PESD_UM_01 = 8'h01;
  localparam logic [7:0] PESD_UM_02 = 8'h02;
  localparam logic [7:0] PESD_UM_04 = 8'h04;
  localparam logic [7:0] PESD_UM_05 = 8'h05;
  localparam logic [7:0] PESD_UM_08 = 8'h08;
  localparam logic [7:0] PESD_UM_0C = 8'h0C;
  localparam logic [7:0] PESD_UM_10 = 8'h10;
  localparam logic [7:0] PESD_UM_20 = 8'h20;
  localparam logic [7:0] PESD_UM_40 = 8'h40;
  localparam logic [7:0] PESD_UM_60 = 8'h60;
  localparam logic [7:0] PESD_UM_FF = 8'hFF;
  localparam int PESD_BR_NOTTAKEN_BIT = 6;
  localparam int PESD_BR_TAKEN_BIT    = 7;
  localparam int PESD_BR_COND_BIT     = 0;
  localparam int PESD_BR_TYPES        = 6;

  // counter index on which the first-level miss activity masks are valid
  localparam int PESD_L1D_COUNTER_IDX = 2;

endpackage

`default_nettype wire
